// *** hw/acs_scan_ctrl.sv ***
module acs_scan_ctrl #(
   parameter int NUM_HW = 10
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Triggers
   input wire logic extTrigN,
   input wire logic [NUM_HW-1:0] hwTrig,
   // Analog core
   output acs_pkg::acs_conv_req_t convReq,
   input wire logic convDone,
   input wire logic [11:0] convData,
   // System
   input wire logic cpuWake,
   output logic cpuHalt,
   output logic scanEndIrq,
   output logic powerDown
);

   if (NUM_HW < 1 || NUM_HW > 14)
   begin : g_chk
      $error("NUM_HW must be 1 to 14");
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [4:0] nextChan(input logic [20:0] m, input logic [4:0] from);
      logic [4:0] r;
      r = acs_pkg::CH_NONE;
      for (int i = acs_pkg::NUM_CH - 1; i >= 0; i--)
         if (m[i] && 5'(i) >= from)
            r = 5'(i);
      return r;
   endfunction

   function automatic logic [7:0] clampSst(input logic [7:0] v);
      return (v < acs_pkg::SST_MIN) ? acs_pkg::SST_MIN : v;
   endfunction

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   acs_pkg::acs_cfg_t cfg;
   acs_pkg::acs_state_t state;
   logic [20:0] chSel, addEn, scanMask;
   logic [7:0] analogSst, sensorSst, sst, sampCnt;
   logic [15:0] results [acs_pkg::NUM_RES];
   logic [15:0] image;
   logic [13:0] acc;
   logic [4:0] chan, firstChan, nxtChan, resIdx, storeIdx;
   logic [1:0] repCnt;
   logic [31:0] rdData;
   logic apbHit, wr, rd, wrCtrl, wrCfg, resHit, rdOk;
   logic armed, haltEn, scanEndFlag, extPrev, trigHit, swGo, scanStart;
   logic isAdd, storeEn, scanDone, contEff, stopReq, tick, haltNow;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   // Writes land only at the edge where the master sees pready
   assign apbHit = psel && penable && pready;
   assign wr = apbHit && pwrite;
   assign rd = apbHit && !pwrite;
   assign wrCtrl = wr && paddr == acs_pkg::OFS_CTRL;
   assign wrCfg = wr && paddr == acs_pkg::OFS_CFG;
   assign resHit = paddr >= acs_pkg::OFS_RES0 && paddr <= acs_pkg::OFS_RES_LAST && paddr[1:0] == 2'h0;
   assign resIdx = 5'((paddr - acs_pkg::OFS_RES0) >> 2);
   assign stopReq = wrCtrl && (pwdata[acs_pkg::CTRL_STOP] || pwdata[acs_pkg::CTRL_SHUT]);

   // ---------------------------------------------------------------
   // Configuration
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cfg <= acs_pkg::CFG_RESET;
         chSel <= 21'h000000;
         addEn <= 21'h000000;
         analogSst <= acs_pkg::SST_RESET;
         sensorSst <= acs_pkg::SST_RESET;
         haltEn <= 1'b0;
      end
      else
      begin
         if (wrCfg)
            cfg <= pwdata[acs_pkg::CFG_W-1:0];
         if (wr && paddr == acs_pkg::OFS_CHSEL)
            chSel <= pwdata[20:0];
         if (wr && paddr == acs_pkg::OFS_ADDEN)
            addEn <= pwdata[20:0] & chSel;
         if (wr && paddr == acs_pkg::OFS_ASST)
            analogSst <= clampSst(pwdata[7:0]);
         if (wr && paddr == acs_pkg::OFS_SSST)
            sensorSst <= clampSst(pwdata[7:0]);
         if (wrCtrl && pwdata[acs_pkg::CTRL_START])
            haltEn <= pwdata[acs_pkg::CTRL_HALT];
      end
   end

   // ---------------------------------------------------------------
   // Power-down
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         powerDown <= 1'b1;
      else if (wrCtrl && pwdata[acs_pkg::CTRL_SHUT])
         powerDown <= 1'b1;
      else if (wrCfg)
         powerDown <= 1'b0;
   end

   // ---------------------------------------------------------------
   // Triggers
   // ---------------------------------------------------------------
   // Pin seen low at one edge after high at the previous one
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         extPrev <= 1'b1;
      else
         extPrev <= extTrigN;
   end

   always_comb
   begin
      trigHit = 1'b0;
      if (cfg.trigSel == acs_pkg::TRG_PIN)
         trigHit = extPrev && !extTrigN;
      else if (cfg.trigSel >= acs_pkg::TRG_HW0 && 32'(cfg.trigSel - acs_pkg::TRG_HW0) < NUM_HW)
         trigHit = hwTrig[cfg.trigSel - acs_pkg::TRG_HW0];
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         armed <= 1'b0;
      else if (stopReq)
         armed <= 1'b0;
      else if (wrCtrl && pwdata[acs_pkg::CTRL_START] && !powerDown)
         armed <= (cfg.trigSel != acs_pkg::TRG_SOFT);
   end

   // ---------------------------------------------------------------
   // Scan sequencer
   // ---------------------------------------------------------------
   assign scanMask = (cfg.source == acs_pkg::SRC_AN) ? chSel : 21'h000001;
   assign firstChan = nextChan(scanMask, 5'h00);
   assign nxtChan = nextChan(scanMask, 5'(chan + 5'h01));
   assign swGo = wrCtrl && pwdata[acs_pkg::CTRL_START] && cfg.trigSel == acs_pkg::TRG_SOFT;
   // Software start sees its own halt bit, not the one latched before
   assign haltNow = swGo ? pwdata[acs_pkg::CTRL_HALT] : haltEn;
   assign scanStart = state == acs_pkg::S_IDLE && !powerDown && !stopReq && firstChan != acs_pkg::CH_NONE &&
                      (swGo || (armed && trigHit));
   assign sst = (cfg.source == acs_pkg::SRC_TS) ? sensorSst : analogSst;
   assign isAdd = (cfg.source == acs_pkg::SRC_AN) ? (addEn[chan] && chSel[chan]) :
                  (cfg.source == acs_pkg::SRC_TS) ? cfg.addTs : cfg.addRef;
   // Continuous only on analog pins; sensor and reference stay single
   assign contEff = cfg.contScan && cfg.source == acs_pkg::SRC_AN;
   assign storeEn = state == acs_pkg::S_STORE;
   assign storeIdx = (cfg.source == acs_pkg::SRC_AN) ? chan : acs_pkg::RES_IDX_SENS;
   assign scanDone = storeEn && nxtChan == acs_pkg::CH_NONE;

   acs_clk_div u_div
   (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .div(cfg.div),
      .tick(tick)
   );

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= acs_pkg::S_IDLE;
         chan <= 5'h00;
         repCnt <= 2'h0;
         acc <= 14'h0000;
         sampCnt <= 8'h00;
         convReq <= '0;
      end
      else if (stopReq || powerDown)
      begin
         state <= acs_pkg::S_IDLE;
         convReq <= '0;
      end
      else
      begin
         convReq.start <= 1'b0;
         convReq.source <= cfg.source;
         convReq.chan <= chan;
         unique case (state)
            acs_pkg::S_IDLE:
               if (scanStart)
               begin
                  state <= acs_pkg::S_SAMPLE;
                  chan <= firstChan;
                  repCnt <= 2'h0;
                  acc <= 14'h0000;
                  sampCnt <= 8'h00;
                  convReq.sample <= 1'b1;
               end
            acs_pkg::S_SAMPLE:
               if (tick)
               begin
                  sampCnt <= 8'(sampCnt + 8'h01);
                  if (sampCnt == 8'(sst - 8'h01))
                  begin
                     state <= acs_pkg::S_CONV;
                     convReq.sample <= 1'b0;
                     convReq.start <= 1'b1;
                  end
               end
            acs_pkg::S_CONV:
               if (convDone)
               begin
                  acc <= 14'(acc + {2'h0, convData});
                  if (isAdd && repCnt != cfg.addCount)
                  begin
                     repCnt <= 2'(repCnt + 2'h1);
                     sampCnt <= 8'h00;
                     state <= acs_pkg::S_SAMPLE;
                     convReq.sample <= 1'b1;
                  end
                  else
                     state <= acs_pkg::S_STORE;
               end
            acs_pkg::S_STORE:
            begin
               repCnt <= 2'h0;
               acc <= 14'h0000;
               sampCnt <= 8'h00;
               if (!scanDone)
               begin
                  chan <= nxtChan;
                  state <= acs_pkg::S_SAMPLE;
                  convReq.sample <= 1'b1;
               end
               else if (contEff)
               begin
                  chan <= firstChan;
                  state <= acs_pkg::S_SAMPLE;
                  convReq.sample <= 1'b1;
               end
               else
                  state <= acs_pkg::S_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Results
   // ---------------------------------------------------------------
   acs_result_fmt u_fmt
   (
      .sum(acc),
      .isAdd(isAdd),
      .alignLeft(cfg.alignLeft),
      .image(image)
   );

   // A store in the same cycle as a clearing read wins
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < acs_pkg::NUM_RES; i++)
            results[i] <= 16'h0000;
      end
      else
      begin
         if (rd && resHit && cfg.clearOnRead)
            results[resIdx] <= 16'h0000;
         if (storeEn)
            results[storeIdx] <= image;
      end
   end

   // ---------------------------------------------------------------
   // Events and CPU halt
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         scanEndIrq <= 1'b0;
         scanEndFlag <= 1'b0;
         cpuHalt <= 1'b0;
      end
      else
      begin
         scanEndIrq <= scanDone;
         if (scanDone)
            scanEndFlag <= 1'b1;
         else if (wr && paddr == acs_pkg::OFS_STAT && pwdata[acs_pkg::STAT_END])
            scanEndFlag <= 1'b0;
         if (scanStart && haltNow)
            cpuHalt <= 1'b1;
         else if (scanDone || cpuWake)
            cpuHalt <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // APB read and response
   // ---------------------------------------------------------------
   always_comb
   begin
      rdData = 32'h00000000;
      rdOk = 1'b1;
      case (paddr)
         acs_pkg::OFS_CTRL: rdData[acs_pkg::CTRL_HALT] = haltEn;
         acs_pkg::OFS_CFG: rdData[acs_pkg::CFG_W-1:0] = cfg;
         acs_pkg::OFS_CHSEL: rdData[20:0] = chSel;
         acs_pkg::OFS_ADDEN: rdData[20:0] = addEn;
         acs_pkg::OFS_ASST: rdData[7:0] = analogSst;
         acs_pkg::OFS_SSST: rdData[7:0] = sensorSst;
         acs_pkg::OFS_STAT: rdData[3:0] = {powerDown, armed, state != acs_pkg::S_IDLE, scanEndFlag};
         default:
            if (resHit)
               rdData[15:0] = results[resIdx];
            else
               rdOk = 1'b0;
      endcase
   end

   // One wait state: the answer is registered
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else if (psel && penable && !pready)
      begin
         pready <= 1'b1;
         pslverr <= !rdOk;
         prdata <= pwrite ? 32'h00000000 : rdData;
      end
      else
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   sequence s_done;
      state == acs_pkg::S_STORE && nxtChan == acs_pkg::CH_NONE;
   endsequence

   property p_swStart;
      (swGo && scanStart) |=> state == acs_pkg::S_SAMPLE && convReq.sample;
   endproperty
   a_swStart: assert property (p_swStart) else $error("software start did not begin scan");

   property p_stop;
      (wrCtrl && pwdata[acs_pkg::CTRL_STOP]) |=> state == acs_pkg::S_IDLE && !armed;
   endproperty
   a_stop: assert property (p_stop) else $error("stop left scan running or armed");

   property p_down;
      (wrCtrl && pwdata[acs_pkg::CTRL_SHUT]) |=> powerDown && state == acs_pkg::S_IDLE;
   endproperty
   a_down: assert property (p_down) else $error("shutdown did not power down");

   property p_wake;
      (wrCfg && !(wrCtrl && pwdata[acs_pkg::CTRL_SHUT])) |=> !powerDown;
   endproperty
   a_wake: assert property (p_wake) else $error("configure did not leave power-down");

   property p_halt;
      (scanStart && haltNow) |=> cpuHalt;
   endproperty
   a_halt: assert property (p_halt) else $error("cpu not halted at scan start");

   property p_irq;
      s_done |=> (scanEndIrq && scanEndFlag) ##1 !scanEndIrq;
   endproperty
   a_irq: assert property (p_irq) else $error("scan end event or flag missing");

   property p_single;
      (s_done and !contEff && !stopReq) |=> state == acs_pkg::S_IDLE;
   endproperty
   a_single: assert property (p_single) else $error("single scan did not stop");

   property p_sst;
      analogSst >= acs_pkg::SST_MIN && sensorSst >= acs_pkg::SST_MIN;
   endproperty
   a_sst: assert property (p_sst) else $error("sampling state count below minimum");

   property p_left;
      (storeEn && isAdd) |=> results[$past(storeIdx)][1:0] == 2'h0;
   endproperty
   a_left: assert property (p_left) else $error("addition result not left aligned");

   property p_clr;
      (rd && resHit && cfg.clearOnRead && !(storeEn && storeIdx == resIdx)) |=> results[$past(resIdx)] == 16'h0000;
   endproperty
   a_clr: assert property (p_clr) else $error("result not cleared by read");

endmodule // acs_scan_ctrl

// *** hw/acs_pkg.sv ***
package acs_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int NUM_CH = 21;
   localparam int NUM_RES = 22;
   localparam logic [4:0] RES_IDX_SENS = 5'h15;
   localparam logic [4:0] CH_NONE = 5'h1F;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CFG = 8'h04;
   localparam logic [7:0] OFS_CHSEL = 8'h08;
   localparam logic [7:0] OFS_ADDEN = 8'h0C;
   localparam logic [7:0] OFS_ASST = 8'h10;
   localparam logic [7:0] OFS_SSST = 8'h14;
   localparam logic [7:0] OFS_STAT = 8'h18;
   localparam logic [7:0] OFS_RES0 = 8'h40;
   localparam logic [7:0] OFS_RES_LAST = 8'h94;

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int CTRL_START = 0;
   localparam int CTRL_STOP = 1;
   localparam int CTRL_HALT = 2;
   localparam int CTRL_SHUT = 3;
   localparam int STAT_END = 0;
   localparam int STAT_BUSY = 1;
   localparam int STAT_ARMED = 2;
   localparam int STAT_DOWN = 3;
   localparam int CFG_W = 15;
   localparam logic [CFG_W-1:0] CFG_RESET = 15'h0000;
   localparam logic [7:0] SST_MIN = 8'h0A;
   localparam logic [7:0] SST_RESET = 8'h14;

   // ---------------------------------------------------------------
   // Encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] SRC_AN = 2'h0;
   localparam logic [1:0] SRC_TS = 2'h1;
   localparam logic [1:0] SRC_REF = 2'h2;
   localparam logic [3:0] TRG_SOFT = 4'h0;
   localparam logic [3:0] TRG_PIN = 4'h1;
   localparam logic [3:0] TRG_HW0 = 4'h2;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic addRef;
      logic addTs;
      logic [1:0] addCount;
      logic [3:0] trigSel;
      logic [1:0] source;
      logic clearOnRead;
      logic alignLeft;
      logic [1:0] div;
      logic contScan;
   } acs_cfg_t;

   typedef struct packed {
      logic sample;
      logic start;
      logic [1:0] source;
      logic [4:0] chan;
   } acs_conv_req_t;

   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_SAMPLE = 4'b0010,
      S_CONV = 4'b0100,
      S_STORE = 4'b1000
   } acs_state_t;

endpackage

// *** hw/acs_clk_div.sv ***
module acs_clk_div
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Ratio select and tick
   input wire logic [1:0] div,
   output logic tick
);

   logic [2:0] cnt;
   logic [2:0] limit;

   // ---------------------------------------------------------------
   // Divider
   // ---------------------------------------------------------------
   // Ratio latched only at a tick so a period is never cut short
   assign tick = (cnt == limit);

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt <= 3'h0;
         limit <= 3'h0;
      end
      else if (tick)
      begin
         cnt <= 3'h0;
         limit <= 3'((4'h1 << div) - 4'h1);
      end
      else
      begin
         cnt <= 3'(cnt + 3'h1);
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence s_gap8;
      !tick [*7] ##1 tick;
   endsequence

   property p_div8;
      @(posedge sys_clk) disable iff (!rstn)
      (tick && div == 2'h3) |=> s_gap8;
   endproperty
   a_div8: assert property (p_div8) else $error("divide by eight period wrong");

endmodule // acs_clk_div

// *** hw/acs_result_fmt.sv ***
module acs_result_fmt
(
   // Accumulated value and mode
   input wire logic [13:0] sum,
   input wire logic isAdd,
   input wire logic alignLeft,
   // Register image
   output logic [15:0] image
);

   // ---------------------------------------------------------------
   // Placement
   // ---------------------------------------------------------------
   always_comb
   begin
      if (isAdd)
         image = {sum, 2'h0};
      else if (alignLeft)
         image = {sum[11:0], 4'h0};
      else
         image = {4'h0, sum[11:0]};
   end

endmodule // acs_result_fmt

// *** tb/test_acs_scan_ctrl.sv ***
module test_acs_scan_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   // ----
   // Signals
   // ----
   logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, extTrigN, convDone, cpuWake, cpuHalt;
   logic scanEndIrq, powerDown, haltSeen, err, add, got;
   logic [7:0] paddr, resA, prevA;
   logic [31:0] pwdata, prdata, rnd, rd, cfgv, expv, prevE;
   logic [9:0] hwTrig;
   logic [11:0] convData;
   logic [13:0] accum;
   logic [6:0] expConv;
   acs_pkg::acs_conv_req_t convReq;
   int errors, tests_run, i, j, ch;

   acs_scan_ctrl DUT (.sys_clk(sys_clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .extTrigN(extTrigN), .hwTrig(hwTrig), .convReq(convReq), .convDone(convDone), .convData(convData),
      .cpuWake(cpuWake), .cpuHalt(cpuHalt), .scanEndIrq(scanEndIrq), .powerDown(powerDown));

   // ----
   // Helpers
   // ----
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   function automatic logic [31:0] expImage(input logic a, input logic l, input logic [13:0] s);
      if (a)
         return {16'h0000, s, 2'h0};
      return l ? {16'h0000, s[11:0], 4'h0} : {20'h00000, s[11:0]};
   endfunction

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // One wait state is normal, but the wait is bounded, not assumed
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      penable <= 1'b0;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
         errors++;
   endtask

   task automatic waitIrq(output logic g);
      int n;
      g = 1'b0;
      for (n = 0; n < 3000 && g !== 1'b1; n++)
      begin
         @(posedge sys_clk);
         g = scanEndIrq;
      end
   endtask

   // Pin low for two clocks, above the minimum width
   task automatic fire(input int k);
      if (k == 0)
         extTrigN <= 1'b0;
      else
         hwTrig <= 10'h008;
      repeat (2) @(posedge sys_clk);
      extTrigN <= 1'b1;
      hwTrig <= 10'h000;
   endtask

   // Analog core stand-in; the sum is kept here from the data it hands out
   always @(posedge sys_clk)
   begin
      convDone <= 1'b0;
      if (convReq.start === 1'b1)
      begin
         rnd = lfsr(rnd);
         convDone <= 1'b1;
         convData <= rnd[11:0];
         accum <= accum + {2'h0, rnd[11:0]};
         haltSeen <= cpuHalt;
         chk("convert target", 32'({convReq.source, convReq.chan}), 32'(expConv));
      end
   end

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   initial
   begin
      #400000;
      errors++;
      conclude();
   end

   // ----
   // Sequence
   // ----
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, convDone, convData, cpuWake, hwTrig} = '0;
      extTrigN = 1'b1;
      accum = '0;
      haltSeen = 1'b0;
      rnd = 32'h0001223A;
      errors = 0;
      tests_run = 0;
      rstn = 1'b0;
      repeat (8) @(posedge sys_clk);
      rstn <= 1'b1;
      apb(acs_pkg::OFS_ASST, 1'b0, 32'h0);
      chk("analog count reset", rd, 32'h14);
      apb(acs_pkg::OFS_STAT, 1'b0, 32'h0);
      chk("status reset", rd, 32'h8);
      apb(8'h30, 1'b0, 32'h0);
      chk("unmapped error", err, 32'h1);
      chk("unmapped data", rd, 32'h0);
      rnd = lfsr(rnd);
      apb(acs_pkg::OFS_ASST, 1'b1, rnd % 10);
      apb(acs_pkg::OFS_ASST, 1'b0, 32'h0);
      chk("analog count floor", rd, 32'h0A);
      // 200 states at divide by two, as the sensor run uses: 4 us, at the 4 us floor
      apb(acs_pkg::OFS_SSST, 1'b1, 32'd200);
      apb(acs_pkg::OFS_SSST, 1'b0, 32'h0);
      chk("sensor count", rd, 32'd200);
      for (i = 0; i < 6; i++)
      begin
         rnd = lfsr(rnd);
         ch = rnd % 21;
         add = (i >= 2 && i <= 4);
         cfgv = ((i % 4) << 11) | ((i % 2) << 3) | ((i % 4) << 1);
         // Sensor run keeps single scan
         if (i == 5)
            cfgv = cfgv | (32'(acs_pkg::SRC_TS) << 5);
         apb(acs_pkg::OFS_CFG, 1'b1, cfgv);
         @(negedge sys_clk);
         chk("leave power down", powerDown, 32'h0);
         apb(acs_pkg::OFS_CHSEL, 1'b1, 32'h1 << ch);
         apb(acs_pkg::OFS_ADDEN, 1'b1, add ? 32'h001FFFFF : 32'h0);
         apb(acs_pkg::OFS_ADDEN, 1'b0, 32'h0);
         chk("add enable", rd, add ? 32'h1 << ch : 32'h0);
         accum = '0;
         expConv = (i == 5) ? {acs_pkg::SRC_TS, 5'h00} : {acs_pkg::SRC_AN, 5'(ch)};
         // No settling wait before the start: the logic does not time it
         apb(acs_pkg::OFS_CTRL, 1'b1, (i == 1) ? 32'h5 : 32'h1);
         waitIrq(got);
         chk("scan end", got, 32'h1);
         chk("cpu halt", haltSeen, 32'(i == 1));
         expv = expImage(add, i % 2 == 1, accum);
         resA = (i == 5) ? acs_pkg::OFS_RES_LAST : 8'(acs_pkg::OFS_RES0 + 4 * ch);
         apb(resA, 1'b0, 32'h0);
         chk("result", rd, expv);
         if (i > 0 && prevA != resA)
         begin
            apb(prevA, 1'b0, 32'h0);
            chk("result kept", rd, prevE);
         end
         apb(acs_pkg::OFS_STAT, 1'b0, 32'h0);
         chk("scan end flag", rd, 32'h1);
         apb(acs_pkg::OFS_STAT, 1'b1, 32'h1);
         prevA = resA;
         prevE = expv;
      end
      expConv = {acs_pkg::SRC_AN, 5'(ch)};
      // Continuous scan with clear-on-read and halt, woken early
      apb(acs_pkg::OFS_CFG, 1'b1, 32'h11);
      apb(acs_pkg::OFS_CTRL, 1'b1, 32'h5);
      @(negedge sys_clk);
      chk("cpu halt at start", cpuHalt, 32'h1);
      @(posedge sys_clk);
      cpuWake <= 1'b1;
      @(posedge sys_clk);
      cpuWake <= 1'b0;
      @(negedge sys_clk);
      chk("cpu woken", cpuHalt, 32'h0);
      waitIrq(got);
      waitIrq(got);
      chk("continuous rescan", got, 32'h1);
      apb(acs_pkg::OFS_CTRL, 1'b1, 32'h2);
      apb(8'(acs_pkg::OFS_RES0 + 4 * ch), 1'b0, 32'h0);
      apb(8'(acs_pkg::OFS_RES0 + 4 * ch), 1'b0, 32'h0);
      chk("clear on read", rd, 32'h0);
      apb(acs_pkg::OFS_STAT, 1'b1, 32'h1);
      for (j = 0; j < 2; j++)
      begin
         apb(acs_pkg::OFS_CFG, 1'b1, 32'(j == 0 ? acs_pkg::TRG_PIN : acs_pkg::TRG_HW0 + 4'h3) << 7);
         apb(acs_pkg::OFS_CTRL, 1'b1, 32'h1);
         apb(acs_pkg::OFS_STAT, 1'b0, 32'h0);
         chk("armed", rd, 32'h4);
         fire(j);
         waitIrq(got);
         chk("trigger scan", got, 32'h1);
         apb(acs_pkg::OFS_STAT, 1'b1, 32'h1);
      end
      apb(acs_pkg::OFS_CTRL, 1'b1, 32'h2);
      apb(acs_pkg::OFS_STAT, 1'b0, 32'h0);
      chk("disarmed", rd, 32'h0);
      fire(1);
      // Idle wait also leaves the stop time to settle before shutdown
      waitIrq(got);
      chk("no scan after stop", got, 32'h0);
      apb(acs_pkg::OFS_CTRL, 1'b1, 32'h8);
      @(negedge sys_clk);
      chk("shutdown", powerDown, 32'h1);
      apb(acs_pkg::OFS_CTRL, 1'b1, 32'h1);
      apb(acs_pkg::OFS_STAT, 1'b0, 32'h0);
      chk("start while down", rd, 32'h8);
      conclude();
   end
endmodule // test_acs_scan_ctrl
